// ---- hw/dead_time_params.svh ----
`ifndef DEAD_TIME_PARAMS_SVH
`define DEAD_TIME_PARAMS_SVH

// register offsets on the configuration port
`define DT_ADDR_EDGES_ONE_TWO 8'h69
`define DT_ADDR_EDGES_THREE_FOUR 8'h6A
// reset value of both offset registers
`define DT_REG_RESET 8'h00
// value returned for an unmapped read
`define DT_UNMAPPED_READ 8'h00
// field positions inside each register
`define DT_SIGN_FIRST_POS 7
`define DT_CODE_FIRST_LSB 4
`define DT_SIGN_SECOND_POS 3
`define DT_CODE_SECOND_LSB 0
`define DT_CODE_W 3
// offset step and largest offset in ns
`define DT_STEP_NS 7'h05
`define DT_MAX_NS 35
// threshold code that disables adaptive offsets
`define DT_THR_OFF 3'h0

`endif

// ---- hw/dead_time_pkg.sv ----
package dead_time_pkg;
   // one signed edge offset in ns, two's complement
   typedef logic [6:0] offset_ns_type;
   // offsets of the four edges, index 0 is the first edge
   typedef logic [3:0][6:0] edge_offsets_type;
   // all state of the top module
   typedef struct packed {
      logic [7:0] dt12_r;
      logic [7:0] dt34_r;
      logic [3:0][6:0] applied_r;
      logic adaptive_r;
      logic [7:0] rdata_r;
      logic rvalid_r;
   } state_type;
endpackage : dead_time_pkg

// ---- hw/edge_offset_if.sv ----
`timescale 1ns/1ns
// carries the register images to the decoder and the decoded offsets back
interface edge_offset_if;
   logic [7:0] dt12; // edges one and two register image
   logic [7:0] dt34; // edges three and four register image
   dead_time_pkg::edge_offsets_type offset_ns; // decoded signed offsets
   modport src (output dt12, output dt34, input offset_ns);
   modport dec (input dt12, input dt34, output offset_ns);
endinterface : edge_offset_if

// ---- hw/edge_offset_decode.sv ----
`timescale 1ns/1ns
`include "dead_time_params.svh"
// turns sign and code fields into signed ns offsets, one per edge
module edge_offset_decode (
   edge_offset_if.dec port_if
);
   // signed offset from a sign bit and a 3-bit step code
   function automatic dead_time_pkg::offset_ns_type decode_offset(input logic sign,
                                                                 input logic [2:0] code);
      dead_time_pkg::offset_ns_type mag;
      mag = 7'({4'h0, code} * `DT_STEP_NS);
      // clear sign means later, set sign means earlier
      decode_offset = sign ? 7'(-mag) : mag;
   endfunction : decode_offset

   // one decoder per edge; even-index edges (first, third) use the upper fields
   for (genvar e = 0; e < 4; e++) begin : g_edge
      localparam int SIGN_POS = (e % 2 == 0) ? `DT_SIGN_FIRST_POS : `DT_SIGN_SECOND_POS;
      localparam int CODE_LSB = (e % 2 == 0) ? `DT_CODE_FIRST_LSB : `DT_CODE_SECOND_LSB;
      logic [7:0] src; // register that holds this edge
      assign src = (e < 2) ? port_if.dt12 : port_if.dt34;
      assign port_if.offset_ns[e] = decode_offset(src[SIGN_POS],
                                                  src[CODE_LSB +: `DT_CODE_W]);
   end
endmodule : edge_offset_decode

// ---- hw/dead_time_edge_offsets.sv ----
// Summary of operation
// - sign bit clear is later, set earlier
// - first edge shifts by bits 6:4 times 5ns
// - second edge shifts by bits 2:0 times 5ns
// - third edge shifts by bits 6:4 times 5ns
// - fourth edge shifts by bits 2:0 times 5ns
// - offsets only while current below threshold
// - threshold code zero disables, steps eighth scale
`timescale 1ns/1ns
`include "dead_time_params.svh"
module dead_time_edge_offsets #(
   parameter int CS_W = 8 // width of the sensed current sample
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic cfg_wr_in,
   input wire logic cfg_rd_in,
   input wire logic [7:0] cfg_wdata_in,
   input wire logic [CS_W-1:0] secondary_current_sense_in,
   input wire logic [2:0] threshold_code_in,
   input wire logic period_start_in,
   output logic [7:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   output logic [3:0][6:0] edge_offset_ns_out,
   output logic adaptive_active_out
);
   // refuse a sample too narrow to hold eighth steps
   if (CS_W < 3) begin : g_bad_width
      $error("CS_W must be at least 3");
   end

   // registered state and its next value
   dead_time_pkg::state_type st_r;
   dead_time_pkg::state_type st_nxt;
   // carrier to the decoder
   edge_offset_if dec_if ();
   // threshold in sample counts
   logic [CS_W:0] threshold_w;
   // offsets wanted for the coming period
   logic use_offsets_w;

   // address match, shared by read and write
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction : hit

   // decoder fed from the stored register images
   assign dec_if.dt12 = st_r.dt12_r;
   assign dec_if.dt34 = st_r.dt34_r;

   edge_offset_decode u_decode (
      .port_if(dec_if)
   );

   // each code step is one eighth of the sample full scale
   // a shift instead of zero padding, so the narrowest legal sample still elaborates
   assign threshold_w = (CS_W + 1)'(threshold_code_in) << (CS_W - 3);
   // code zero disables, else offsets only below threshold
   assign use_offsets_w = (threshold_code_in != `DT_THR_OFF) &&
                          ({1'b0, secondary_current_sense_in} < threshold_w);

   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid_r = 1'b0;
      // register writes
      if (cfg_wr_in) begin
         if (hit(cfg_addr_in, `DT_ADDR_EDGES_ONE_TWO)) begin
            st_nxt.dt12_r = cfg_wdata_in;
         end else if (hit(cfg_addr_in, `DT_ADDR_EDGES_THREE_FOUR)) begin
            st_nxt.dt34_r = cfg_wdata_in;
         end
      end
      // register reads, answered one cycle later
      if (cfg_rd_in) begin
         st_nxt.rvalid_r = 1'b1;
         if (hit(cfg_addr_in, `DT_ADDR_EDGES_ONE_TWO)) begin
            st_nxt.rdata_r = st_r.dt12_r;
         end else if (hit(cfg_addr_in, `DT_ADDR_EDGES_THREE_FOUR)) begin
            st_nxt.rdata_r = st_r.dt34_r;
         end else begin
            st_nxt.rdata_r = `DT_UNMAPPED_READ;
         end
      end
      // offsets change only at a period boundary
      if (period_start_in) begin
         st_nxt.adaptive_r = use_offsets_w;
         if (use_offsets_w) begin
            st_nxt.applied_r = dec_if.offset_ns;
         end else begin
            st_nxt.applied_r = '0; // nominal timing
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r.dt12_r <= `DT_REG_RESET;
         st_r.dt34_r <= `DT_REG_RESET;
         st_r.applied_r <= '0;
         st_r.adaptive_r <= 1'b0;
         st_r.rdata_r <= 8'h00;
         st_r.rvalid_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   assign cfg_rdata_out = st_r.rdata_r;
   assign cfg_rvalid_out = st_r.rvalid_r;
   assign edge_offset_ns_out = st_r.applied_r;
   assign adaptive_active_out = st_r.adaptive_r;

   // checks on the design's own behaviour
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // clear sign with nonzero code moves the first edge later
   a_sign_clear_later: assert property (
      period_start_in && use_offsets_w && !st_r.dt12_r[7] && (st_r.dt12_r[6:4] != 3'h0)
      |=> $signed(edge_offset_ns_out[0]) > 0)
      else $error("positive sign gave no later edge");

   // set sign with nonzero code moves the third edge earlier
   a_sign_set_earlier: assert property (
      period_start_in && use_offsets_w && st_r.dt34_r[7] && (st_r.dt34_r[6:4] != 3'h0)
      |=> $signed(edge_offset_ns_out[2]) < 0)
      else $error("negative sign gave no earlier edge");

   // first edge magnitude is code times step
   a_first_edge_size: assert property (
      period_start_in && use_offsets_w
      |=> (($past(st_r.dt12_r[7]) ? -$signed(edge_offset_ns_out[0])
                                  : $signed(edge_offset_ns_out[0]))
           == int'($past(st_r.dt12_r[6:4])) * 5))
      else $error("first edge offset wrong");

   // second edge magnitude is code times step
   a_second_edge_size: assert property (
      period_start_in && use_offsets_w
      |=> (($past(st_r.dt12_r[3]) ? -$signed(edge_offset_ns_out[1])
                                  : $signed(edge_offset_ns_out[1]))
           == int'($past(st_r.dt12_r[2:0])) * 5))
      else $error("second edge offset wrong");

   // third edge magnitude is code times step
   a_third_edge_size: assert property (
      period_start_in && use_offsets_w
      |=> (($past(st_r.dt34_r[7]) ? -$signed(edge_offset_ns_out[2])
                                  : $signed(edge_offset_ns_out[2]))
           == int'($past(st_r.dt34_r[6:4])) * 5))
      else $error("third edge offset wrong");

   // fourth edge magnitude is code times step, never past the largest
   a_fourth_edge_size: assert property (
      period_start_in && use_offsets_w
      |=> (($past(st_r.dt34_r[3]) ? -$signed(edge_offset_ns_out[3])
                                  : $signed(edge_offset_ns_out[3]))
           == int'($past(st_r.dt34_r[2:0])) * 5)
          && ($signed(edge_offset_ns_out[3]) <= `DT_MAX_NS))
      else $error("fourth edge offset wrong");

   // at or above threshold all edges are nominal
   a_above_nominal: assert property (
      period_start_in && (threshold_code_in != 3'h0)
      && ({1'b0, secondary_current_sense_in} >= threshold_w)
      |=> (edge_offset_ns_out == '0) && !adaptive_active_out)
      else $error("offsets applied above threshold");

   // threshold code zero disables whatever the current
   a_code_zero_off: assert property (
      period_start_in && (threshold_code_in == 3'h0)
      |=> (edge_offset_ns_out == '0) && !adaptive_active_out)
      else $error("code zero did not disable offsets");

   // threshold is code times one eighth of full scale
   a_threshold_step: assert property (
      threshold_w == (CS_W + 1)'(int'(threshold_code_in) * (2 ** (CS_W - 3))))
      else $error("threshold step wrong");

   // offsets hold between period starts even across writes
   a_hold_mid_period: assert property (
      !period_start_in ##1 1'b1 |-> $stable(edge_offset_ns_out))
      else $error("offset changed inside a period");

   // a write shows on a read two cycles on
   a_write_readback: assert property (
      cfg_wr_in && hit(cfg_addr_in, `DT_ADDR_EDGES_ONE_TWO) ##1
      cfg_rd_in && !cfg_wr_in && hit(cfg_addr_in, `DT_ADDR_EDGES_ONE_TWO)
      |=> cfg_rvalid_out && (cfg_rdata_out == $past(cfg_wdata_in, 2)))
      else $error("register readback mismatch");

   // every read is answered on the next cycle
   a_read_answer: assert property (
      cfg_rd_in |=> cfg_rvalid_out)
      else $error("read not answered");

   // no answer without a read the cycle before
   a_no_stray_valid: assert property (
      !cfg_rd_in |=> !cfg_rvalid_out)
      else $error("read answer without a read");

   // reads of other addresses return the fixed value
   a_unmapped_read: assert property (
      cfg_rd_in && !hit(cfg_addr_in, `DT_ADDR_EDGES_ONE_TWO)
      && !hit(cfg_addr_in, `DT_ADDR_EDGES_THREE_FOUR)
      |=> cfg_rdata_out == `DT_UNMAPPED_READ)
      else $error("unmapped read returned data");

   // read data holds until the next read
   a_rdata_hold: assert property (
      !cfg_rd_in |=> $stable(cfg_rdata_out))
      else $error("read data changed without a read");

   // adaptive flag changes only at a period start
   a_flag_hold: assert property (
      !period_start_in |=> $stable(adaptive_active_out))
      else $error("adaptive flag changed inside a period");

   // main scenarios
   c_offsets_applied: cover property (period_start_in && use_offsets_w ##1
                                      edge_offset_ns_out != '0);
   c_negative_edge: cover property (##1 $signed(edge_offset_ns_out[1]) < 0);
   c_above_threshold: cover property (adaptive_active_out ##1 period_start_in
                                      && !use_offsets_w);
   c_write_mid_period: cover property (cfg_wr_in && !period_start_in);
endmodule : dead_time_edge_offsets

// ---- tb/pwm_edge_model.sv ----
`timescale 1ns/1ns
// stands in for the pwm edge generator: free running switching period
module pwm_edge_model #(
   parameter int PERIOD = 8 // cycles per switching period
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   output logic period_start_out
);
   logic [7:0] count_r; // position inside the period
   // one pulse at the start of every period
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_r <= 8'h00;
         period_start_out <= 1'b0;
      end else begin
         period_start_out <= (count_r == 8'h00);
         count_r <= (count_r == 8'(PERIOD - 1)) ? 8'h00 : count_r + 8'h01;
      end
   end
endmodule : pwm_edge_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   logic sys_clk, rst_n, wr, rd, ps, rvalid, act; // clock, strobes, flags
   logic [7:0] addr, wdata, cur, rdata; // register port and current
   logic [2:0] thr; // threshold code
   logic [3:0][6:0] offs; // offsets seen by the edge generator
   int fail_count, checks; // verdict counters

   dead_time_edge_offsets #(.CS_W(8)) dead_time_edge_offsets_i (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .cfg_addr_in(addr),
      .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_wdata_in(wdata),
      .secondary_current_sense_in(cur), .threshold_code_in(thr),
      .period_start_in(ps), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
      .edge_offset_ns_out(offs), .adaptive_active_out(act));

   pwm_edge_model #(.PERIOD(8)) pwm_edge_model_i (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .period_start_out(ps));

   // one edge offset: code times 5 ns, negated when sign set
   function automatic logic [6:0] one_off(input logic s, input logic [2:0] c);
      logic [6:0] m;
      m = {4'h0, c} * 7'h05;
      return s ? -m : m;
   endfunction : one_off

   // all four offsets from both register images
   function automatic logic [27:0] exp_off(input logic [7:0] a, input logic [7:0] b);
      return {one_off(b[3], b[2:0]), one_off(b[7], b[6:4]),
              one_off(a[3], a[2:0]), one_off(a[7], a[6:4])};
   endfunction : exp_off

   // compare register data or flags
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_reg

   // compare the offset vector
   task automatic cmp_off(input logic [27:0] got, input logic [27:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_off

   // one write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg

   // one read strobe, answer one cycle later
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      cmp_reg({7'h00, rvalid}, 8'h01);
      cmp_reg(rdata, e);
      @(negedge sys_clk);
      cmp_reg({7'h00, rvalid}, 8'h00);
   endtask : rd_reg

   // wait for the next period start, return once outputs settled
   task automatic next_period;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ps !== 1'b1 && n < 20);
      // a missing period start counts as a mismatch
      cmp_reg({7'h00, ps}, 8'h01);
      @(negedge sys_clk);
   endtask : next_period

   // reset values
   task automatic t_reset;
      rd_reg(8'h69, 8'h00);
      rd_reg(8'h6A, 8'h00);
      cmp_off(offs, 28'h0000000);
      cmp_reg({7'h00, act}, 8'h00);
   endtask : t_reset

   // every code on all four edges, sign bit equal to the code's bit 0
   task automatic t_codes;
      logic [7:0] a, b;
      @(posedge sys_clk);
      thr <= 3'h7;
      cur <= 8'h00;
      for (int i = 0; i < 8; i++) begin
         a = {i[0], i[2:0], ~i[0], ~i[2:0]};
         b = {~i[0], ~i[2:0], i[0], i[2:0]};
         wr_reg(8'h69, a);
         wr_reg(8'h6A, b);
         rd_reg(8'h6A, b);
         next_period();
         cmp_off(offs, exp_off(a, b));
      end
   endtask : t_codes

   // each threshold code, current just below and at the threshold
   task automatic t_thresh;
      logic on;
      wr_reg(8'h69, 8'hB5);
      wr_reg(8'h6A, 8'h5C);
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            thr <= 3'(c);
            cur <= 8'(c * 32 - 1 + k);
            on = (c != 0) && (k == 0);
            next_period();
            cmp_reg({7'h00, act}, {7'h00, on});
            cmp_off(offs, on ? exp_off(8'hB5, 8'h5C) : 28'h0);
         end
      end
   endtask : t_thresh

   // write mid period, unmapped access
   task automatic t_hold;
      @(posedge sys_clk);
      thr <= 3'h7;
      cur <= 8'h00;
      next_period();
      wr_reg(8'h69, 8'h3A);
      repeat (2) @(negedge sys_clk);
      cmp_off(offs, exp_off(8'hB5, 8'h5C));
      next_period();
      cmp_off(offs, exp_off(8'h3A, 8'h5C));
      wr_reg(8'h6B, 8'hFF);
      rd_reg(8'h6B, 8'h00);
      rd_reg(8'h69, 8'h3A);
   endtask : t_hold

   // write then read back to back, and a read beside a write
   task automatic t_b2b;
      @(posedge sys_clk);
      addr <= 8'h69;
      wdata <= 8'h11;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge sys_clk);
      wdata <= 8'h22;
      wr <= 1'b1;
      @(negedge sys_clk);
      cmp_reg({7'h00, rvalid}, 8'h01);
      cmp_reg(rdata, 8'h11);
      @(posedge sys_clk);
      wr <= 1'b0;
      @(negedge sys_clk);
      cmp_reg(rdata, 8'h11);
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      cmp_reg(rdata, 8'h22);
   endtask : t_b2b

   // verdict and end of run
   task automatic results;
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // watchdog, well beyond the expected run
   initial begin
      #50000;
      fail_count++;
      results();
   end

   // main sequence
   initial begin
      fail_count = 0;
      checks = 0;
      rst_n = 1'b0;
      {wr, rd, addr, wdata, cur, thr} = '0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_codes();
      t_thresh();
      t_hold();
      t_b2b();
      results();
   end
endmodule : tb_top
